// >>> design/cmd_in_pkg.sv
package cmd_in_pkg;
	// Command codes {cs_n, ras_n, cas_n, we_n} with act_n high
	localparam logic [3:0] CMD_MRS  = 4'h0;
	localparam logic [3:0] CMD_REF  = 4'h1;
	localparam logic [3:0] CMD_PRE  = 4'h2;
	localparam logic [3:0] CMD_RSVD = 4'h3;
	localparam logic [3:0] CMD_WR   = 4'h4;
	localparam logic [3:0] CMD_RD   = 4'h5;
	localparam logic [3:0] CMD_ZQC  = 4'h6;
	localparam logic [3:0] CMD_NOP  = 4'h7;

	// Mode register field positions
	localparam int MR1_TDQS_BIT  = 11;
	localparam int MR5_DM_BIT    = 10;
	localparam int MR5_WDBI_BIT  = 11;
	localparam int MR5_RDBI_BIT  = 12;

	// Reset values
	localparam logic [2:0] CHIP_ID_RST = 3'h0;
	localparam logic [2:0] RTT_NOM_OFF = 3'h0;

	// Stack heights
	localparam int STACK_MAX = 8;

	typedef enum logic [3:0] {
		PWR_ACTIVE = 4'h1,
		PWR_PPD    = 4'h2,
		PWR_APD    = 4'h4,
		PWR_SREF   = 4'h8
	} pwr_state_t;
endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Pin and filtered level
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	if (WIDTH < 1) begin : g_chk_width
		$error("WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Change counts once second and third stage agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					level[i] <= 1'b0;
				end else if (s2_r[i] == s3_r[i]) begin
					level[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule

// >>> design/mask_dbi.sv
`timescale 1ns/1ps
module mask_dbi #(
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Function selects
	input  wire logic          dm_en,
	input  wire logic          wdbi_en,
	input  wire logic          tdqs_en,
	// Write beat in
	input  wire logic          beat_valid,
	input  wire logic [DW-1:0] beat_data,
	input  wire logic          dm_dbi_n,
	// Beat out
	output logic               store_valid,
	output logic      [DW-1:0] store_data,
	output logic               store_en
);
	if (DW < 1) begin : g_chk_width
		$error("DW must be at least 1");
	end

	logic pin_mask;
	logic pin_inv;

	// Pin is mask or inversion flag by mode bits; termination strobe wins
	always_comb begin
		pin_mask = !tdqs_en && dm_en && !dm_dbi_n; // [R15] [R17] [R18]
		pin_inv  = !tdqs_en && wdbi_en && !dm_dbi_n; // [R17] [R19]
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			store_valid <= 1'b0;
			store_data  <= '0;
			store_en    <= 1'b0;
		end else begin
			store_valid <= beat_valid;
			store_data  <= pin_inv ? ~beat_data : beat_data; // [R19]
			store_en    <= beat_valid && !pin_mask; // [R15]
		end
	end
endmodule

// >>> design/cmd_in.sv
`timescale 1ns/1ps
// Contract
// [R1] Capture control and address at clock crossing
// [R2] Clock enable gates clocks, buffers and drivers
// [R3] Enable low: idle power-down/self-refresh or active
// [R4] Self-refresh exit taken synchronously from enable
// [R5] Controller holds enable high during accesses
// [R6] Power-down keeps only clock, termination, enable
// [R7] Self-refresh keeps only clock-enable input buffer
// [R8] Chip select high masks command; selects rank
// [R9] Chip ID selects die in stack
// [R10] Registered termination enable turns on termination
// [R11] Termination on data, strobes, mask, strobe pair
// [R12] Termination input ignored when termination disabled
// [R13] Activation low: command pins are row bits
// [R14] Activation high: pins decode as command
// [R15] Masked write beats are not stored
// [R16] Mask sampled on both strobe edges
// [R17] Mode bits pick mask or inversion function
// [R18] Eight-bit parts: mode bit picks strobe or mask
// [R19] Low inversion flag inverts data byte
// [R20] Bank group selects target group
// [R21] Bank address selects bank within group
// [R22] Mode set uses group and bank bits
// [R23] Decode only with select low, enable high
module cmd_in
	import cmd_in_pkg::*;
#(
	parameter int          DEV_WIDTH  = 8,
	parameter int          STACK      = 1,
	parameter logic [2:0]  MY_CHIP_ID = 3'h0,
	parameter int          ROW_W      = 14
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Clock enable pin
	input  wire logic             cke_pin,
	// Command and address pins
	input  wire logic             cs_n,
	input  wire logic             act_n,
	input  wire logic             ras_n_a16,
	input  wire logic             cas_n_a15,
	input  wire logic             we_n_a14,
	input  wire logic [2:0]       chip_id,
	input  wire logic [1:0]       bg,
	input  wire logic [1:0]       ba,
	input  wire logic [13:0]      addr,
	input  wire logic             odt_pin,
	// Mode settings
	input  wire logic             rtt_nom_en,
	input  wire logic             tdqs_en,
	input  wire logic             dm_en,
	input  wire logic             wdbi_en,
	// Write data beats, one per strobe edge
	input  wire logic             beat_valid,
	input  wire logic [DEV_WIDTH-1:0] beat_data,
	input  wire logic             dm_dbi_n,
	// Bank state
	input  wire logic             any_row_open,
	input  wire logic             sref_req,
	// Decoded command outputs
	output logic                  cmd_valid,
	output logic                  cmd_act,
	output logic      [3:0]       cmd_code,
	output logic      [16:0]      cmd_row,
	output logic      [1:0]       cmd_bg,
	output logic      [1:0]       cmd_ba,
	output logic      [13:0]      cmd_addr,
	output logic                  mrs_valid,
	output logic      [2:0]       mrs_sel,
	// Power and buffer status
	output pwr_state_t            pwr_state,
	output logic                  clk_en_int,
	output logic                  cmd_buf_en,
	output logic                  odt_buf_en,
	output logic                  out_drv_en,
	// Termination
	output logic                  term_dq_en,
	output logic                  term_tdqs_en,
	// Stored beat
	output logic                  store_valid,
	output logic [DEV_WIDTH-1:0]  store_data,
	output logic                  store_en
);
	// Refuse widths and stack heights the logic cannot serve
	if (DEV_WIDTH != 4 && DEV_WIDTH != 8 &&
		DEV_WIDTH != 16) begin : g_chk_width
		$error("DEV_WIDTH must be 4, 8 or 16");
	end
	if (STACK != 1 && STACK != 2 && STACK != 4 &&
		STACK != STACK_MAX) begin : g_chk_stack
		$error("STACK must be 1, 2, 4 or 8");
	end
	if (ROW_W < 1 || ROW_W > 14) begin : g_chk_row
		$error("ROW_W out of range");
	end

	localparam bit X8 = (DEV_WIDTH == 8);
	localparam bit X16 = (DEV_WIDTH == 16);

	// Clock enable is a pin from the controller: filter it
	logic cke;
	pin_sync #(
		.WIDTH (1)
	) u_cke_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (cke_pin),
		.level (cke)
	);

	// All command/address inputs captured on the same edge
	logic             cs_n_r;
	logic             act_n_r;
	logic [2:0]       cmdp_r;
	logic [2:0]       cid_r;
	logic [1:0]       bg_r;
	logic [1:0]       ba_r;
	logic [13:0]      addr_r;
	logic             odt_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_n_r  <= 1'b1;
			act_n_r <= 1'b1;
			cmdp_r  <= 3'h7;
			cid_r   <= CHIP_ID_RST;
			bg_r    <= 2'h0;
			ba_r    <= 2'h0;
			addr_r  <= 14'h0;
		end else if (cmd_buf_en) begin // [R1] [R6] [R7] [R23]
			cs_n_r  <= cs_n;
			act_n_r <= act_n;
			cmdp_r  <= {ras_n_a16, cas_n_a15, we_n_a14};
			cid_r   <= chip_id;
			bg_r    <= X16 ? {1'b0, bg[0]} : bg; // [R20]
			ba_r    <= ba;
			addr_r  <= addr;
		end else begin
			cs_n_r  <= 1'b1;
			act_n_r <= 1'b1;
			cmdp_r  <= 3'h7;
		end
	end

	// Termination pin stays live in power-down, dead in self-refresh
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			odt_r <= 1'b0;
		end else if (odt_buf_en) begin // [R6] [R7]
			odt_r <= odt_pin;
		end else begin
			odt_r <= 1'b0;
		end
	end

	// Die match in stacks; single die ignores chip id
	logic id_match;
	logic [2:0] id_mask;
	always_comb begin
		case (STACK)
			2:       id_mask = 3'h1;
			4:       id_mask = 3'h3;
			8:       id_mask = 3'h7;
			default: id_mask = 3'h0;
		endcase
		id_match = ((cid_r ^ MY_CHIP_ID) & id_mask) == 3'h0; // [R9]
	end

	// A command is live only with select low, enable high, die matched
	logic sel;
	logic [3:0] code;
	always_comb begin
		sel  = !cs_n_r && cke && id_match && (pwr_state == PWR_ACTIVE);
		code = {cs_n_r, cmdp_r}; // [R8] [R14]
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_valid <= 1'b0;
			cmd_act   <= 1'b0;
			cmd_code  <= CMD_NOP;
			cmd_row   <= 17'h0;
			cmd_bg    <= 2'h0;
			cmd_ba    <= 2'h0;
			cmd_addr  <= 14'h0;
			mrs_valid <= 1'b0;
			mrs_sel   <= 3'h0;
		end else begin
			cmd_valid <= sel; // [R8] [R23]
			cmd_act   <= sel && !act_n_r;
			cmd_code  <= act_n_r ? code : CMD_NOP; // [R14]
			// Activation: shared pins become upper row bits
			cmd_row   <= {cmdp_r, addr_r}; // [R13]
			cmd_bg    <= bg_r; // [R20]
			cmd_ba    <= ba_r; // [R21]
			cmd_addr  <= addr_r;
			mrs_valid <= sel && act_n_r && (code == CMD_MRS);
			mrs_sel   <= {bg_r[0], ba_r}; // [R22]
		end
	end

	// Power state, moved only by the filtered enable on clock edges
	pwr_state_t pwr_nxt;
	always_comb begin
		pwr_nxt = pwr_state;
		case (pwr_state)
			PWR_ACTIVE: begin
				if (!cke) begin
					if (any_row_open) // [R3]
						pwr_nxt = PWR_APD;
					else if (sref_req)
						pwr_nxt = PWR_SREF;
					else
						pwr_nxt = PWR_PPD;
				end
			end
			PWR_PPD, PWR_APD: begin
				if (cke)
					pwr_nxt = PWR_ACTIVE;
			end
			PWR_SREF: begin
				if (cke) // [R4]
					pwr_nxt = PWR_ACTIVE;
			end
			default: pwr_nxt = PWR_ACTIVE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			pwr_state <= PWR_ACTIVE;
		else
			pwr_state <= pwr_nxt;
	end

	// Buffer and driver enables follow the power state
	always_comb begin
		clk_en_int = cke; // [R2]
		out_drv_en = cke && (pwr_state == PWR_ACTIVE); // [R2]
		cmd_buf_en = cke && (pwr_state == PWR_ACTIVE); // [R6] [R7]
		odt_buf_en = (pwr_state != PWR_SREF); // [R6] [R7]
	end

	// Nominal termination on the data group
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			term_dq_en   <= 1'b0;
			term_tdqs_en <= 1'b0;
		end else begin
			term_dq_en   <= rtt_nom_en && odt_r; // [R10] [R11] [R12]
			term_tdqs_en <= X8 && tdqs_en && rtt_nom_en && odt_r; // [R11]
		end
	end

	// Termination strobe exists only on eight-bit parts
	logic tdqs_act;
	always_comb begin
		tdqs_act = X8 && tdqs_en; // [R18]
	end

	// One beat per strobe edge, so mask is taken on both edges
	mask_dbi #(
		.DW (DEV_WIDTH)
	) u_mask_dbi (
		.clk         (clk),
		.rst_n       (rst_n),
		.dm_en       (dm_en),
		.wdbi_en     (wdbi_en),
		.tdqs_en     (tdqs_act),
		.beat_valid  (beat_valid && cke), // [R16] [R5]
		.beat_data   (beat_data),
		.dm_dbi_n    (dm_dbi_n),
		.store_valid (store_valid),
		.store_data  (store_data),
		.store_en    (store_en)
	);
endmodule

// >>> tb/cmd_in_properties.sv
`timescale 1ns/1ps
module cmd_in_properties
	import cmd_in_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Device inputs
	input wire logic        cs_n,
	input wire logic        act_n,
	input wire logic        ras_n_a16,
	input wire logic [1:0]  bg,
	input wire logic [1:0]  ba,
	input wire logic        tdqs_en,
	input wire logic        dm_en,
	input wire logic        beat_valid,
	input wire logic        dm_dbi_n,
	input wire logic        any_row_open,
	// Device outputs
	input wire logic        cmd_valid,
	input wire logic        cmd_act,
	input wire logic [16:0] cmd_row,
	input wire logic [1:0]  cmd_bg,
	input wire logic [1:0]  cmd_ba,
	input wire logic        mrs_valid,
	input wire logic [2:0]  mrs_sel,
	input wire pwr_state_t  pwr_state,
	input wire logic        clk_en_int,
	input wire logic        cmd_buf_en,
	input wire logic        odt_buf_en,
	input wire logic        store_valid,
	input wire logic        store_en
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_sel_masks: assert property (cmd_valid |-> !$past(cs_n, 2))
		else $error("command decoded with select high");
	chk_row_bits: assert property (cmd_act |->
		!$past(act_n, 2) && cmd_row[16] == $past(ras_n_a16, 2))
		else $error("activate row bits wrong");
	chk_bank_sel: assert property (cmd_valid |->
		cmd_bg == $past(bg, 2) && cmd_ba == $past(ba, 2))
		else $error("bank group or bank wrong");
	chk_mrs_sel: assert property (mrs_valid |->
		cmd_valid && mrs_sel == {$past(bg[0], 2), $past(ba, 2)})
		else $error("mode register select wrong");
	chk_apd_entry: assert property (pwr_state == PWR_ACTIVE &&
		!clk_en_int && any_row_open |=> pwr_state == PWR_APD)
		else $error("active power-down not entered");
	chk_pd_buffers: assert property (
		pwr_state inside {PWR_PPD, PWR_APD} |-> !cmd_buf_en && odt_buf_en)
		else $error("power-down buffer enables wrong");
	chk_sref_buf: assert property (pwr_state == PWR_SREF |->
		!cmd_buf_en && !odt_buf_en)
		else $error("self-refresh buffer enables wrong");
	chk_mask_beat: assert property ($past(beat_valid) &&
		$past(clk_en_int) && $past(dm_en) && !$past(tdqs_en) &&
		!$past(dm_dbi_n) |-> store_valid && !store_en)
		else $error("masked beat stored");
endmodule

bind cmd_in cmd_in_properties u_cmd_in_properties (
	.clk          (clk),
	.rst_n        (rst_n),
	.cs_n         (cs_n),
	.act_n        (act_n),
	.ras_n_a16    (ras_n_a16),
	.bg           (bg),
	.ba           (ba),
	.tdqs_en      (tdqs_en),
	.dm_en        (dm_en),
	.beat_valid   (beat_valid),
	.dm_dbi_n     (dm_dbi_n),
	.any_row_open (any_row_open),
	.cmd_valid    (cmd_valid),
	.cmd_act      (cmd_act),
	.cmd_row      (cmd_row),
	.cmd_bg       (cmd_bg),
	.cmd_ba       (cmd_ba),
	.mrs_valid    (mrs_valid),
	.mrs_sel      (mrs_sel),
	.pwr_state    (pwr_state),
	.clk_en_int   (clk_en_int),
	.cmd_buf_en   (cmd_buf_en),
	.odt_buf_en   (odt_buf_en),
	.store_valid  (store_valid),
	.store_en     (store_en)
);

// >>> tb/host_ctrl.sv
`timescale 1ns/1ps
module host_ctrl (
	// Clock
	input wire logic    clk,
	// Pins toward the device
	output logic        cke_pin,
	output logic        cs_n,
	output logic        act_n,
	output logic        ras_n_a16,
	output logic        cas_n_a15,
	output logic        we_n_a14,
	output logic [2:0]  chip_id,
	output logic [1:0]  bg,
	output logic [1:0]  ba,
	output logic [13:0] addr,
	output logic        beat_valid,
	output logic [7:0]  beat_data,
	output logic        dm_dbi_n
);
	initial begin
		cke_pin = 1'b1;
		{cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = 5'h1F;
		{chip_id, bg, ba, addr} = '0;
		{beat_valid, beat_data, dm_dbi_n} = '0;
	end
	task automatic cmd(input logic [3:0] c, input logic a,
		input logic [2:0] ci, input logic [1:0] g, input logic [1:0] b,
		input logic [13:0] d);
		@(posedge clk);
		#1;
		{cs_n, ras_n_a16, cas_n_a15, we_n_a14} = c;
		act_n = a;
		chip_id = ci;
		bg = g;
		ba = b;
		addr = d;
	endtask
	task automatic idle();
		@(posedge clk);
		#1;
		cs_n = 1'b1;
		act_n = 1'b1;
		// Deselected lines carry no stale value
		{ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr} =
			~{ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr};
	endtask
	task automatic beat(input logic v, input logic [7:0] d, input logic m);
		@(posedge clk);
		#1;
		beat_valid = v;
		beat_data = v ? d : ~beat_data;
		dm_dbi_n = m;
	endtask
	task automatic set_cke(input logic k);
		@(posedge clk);
		#1;
		cke_pin = k | beat_valid;
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cmd_in_pkg::*;
	logic        clk, rst_n, rtt_nom_en, tdqs_en, dm_en, wdbi_en;
	logic        any_row_open, sref_req, odt_pin, cke_pin, cs_n, act_n;
	logic        ras_n_a16, cas_n_a15, we_n_a14, beat_valid, dm_dbi_n;
	logic        cmd_valid, cmd_act, mrs_valid, clk_en_int, cmd_buf_en;
	logic        odt_buf_en, out_drv_en, term_dq_en, term_tdqs_en;
	logic        store_valid, store_en;
	logic [1:0]  bg, ba, cmd_bg, cmd_ba;
	logic [2:0]  chip_id, mrs_sel;
	logic [3:0]  cmd_code;
	logic [7:0]  beat_data, store_data;
	logic [13:0] addr, cmd_addr;
	logic [16:0] cmd_row;
	logic [31:0] rnd;
	logic [43:0] cmd_seen, cq[$];
	logic [8:0]  st_seen, sq[$];
	pwr_state_t  pwr_state, pst[3];
	int          err_count, total_checks, i, j;

	// Two-high stack, this die answers to odd chip ids
	cmd_in #(.STACK(2), .MY_CHIP_ID(3'h1)) u_cmd_in (.*);
	host_ctrl u_host_ctrl (.*);

	assign cmd_seen = {cmd_act, cmd_code, cmd_row, cmd_bg, cmd_ba, cmd_addr,
		mrs_valid, mrs_valid ? mrs_sel : 3'h0};
	assign st_seen = {store_en, store_en ? store_data : 8'h00};

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic check(input logic [43:0] s, input logic [43:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic send(input logic live);
		logic       a, s, m;
		logic [3:0] c;
		rnd = xs(rnd);
		a = rnd[4];
		s = rnd[3] & rnd[23];
		c = {s, rnd[2:0]};
		m = a && c == CMD_MRS;
		u_host_ctrl.cmd(c, a, rnd[26:24], rnd[6:5], rnd[8:7], rnd[22:9]);
		if (!s && live && rnd[24])
			cq.push_back({!a, a ? c : CMD_NOP, rnd[2:0], rnd[22:9], rnd[6:5],
				rnd[8:7], rnd[22:9], m, m ? {rnd[5], rnd[8:7]} : 3'h0});
	endtask
	task automatic wbeat(input logic v);
		logic [7:0] d;
		logic       m, k, x;
		rnd = xs(rnd);
		d = rnd[7:0];
		m = rnd[8];
		k = dm_en & ~tdqs_en & ~m;
		x = wdbi_en & ~tdqs_en & ~m;
		u_host_ctrl.beat(v, d, m);
		if (v)
			sq.push_back({!k, k ? 8'h00 : x ? ~d : d});
	endtask

	always @(posedge clk) begin
		#2;
		if (rst_n === 1'b1 && cmd_valid !== 1'b0)
			check(cmd_seen,
				cq.size() ? cq.pop_front() : '1);
		if (rst_n === 1'b1 && store_valid !== 1'b0)
			check(44'(st_seen),
				sq.size() ? 44'(sq.pop_front()) : '1);
	end

	initial begin
		{rst_n, rtt_nom_en, tdqs_en, dm_en, wdbi_en} = '0;
		{any_row_open, sref_req, odt_pin} = '0;
		err_count = 0;
		total_checks = 0;
		rnd = 32'hF7D79485;
		pst = '{PWR_APD, PWR_SREF, PWR_PPD};
		repeat (10) tick();
		rst_n = 1'b1;
		repeat (10) tick();
		for (i = 0; i < 60; i++)
			send(1'b1);
		// One fixed mode register set, so that path is always reached
		u_host_ctrl.cmd(CMD_MRS, 1'b1, 3'h1, 2'h1, 2'h2, 14'h0A5);
		cq.push_back({1'b0, CMD_MRS, 3'h0, 14'h0A5, 2'h1, 2'h2, 14'h0A5,
			1'b1, 3'h6});
		u_host_ctrl.idle();
		for (i = 0; i < 8; i++) begin
			// Drop the beat strobe before the mode bits move
			wbeat(1'b0);
			{dm_en, wdbi_en, tdqs_en} = i[2:0];
			for (j = 0; j < 5; j++)
				wbeat(1'b1);
		end
		wbeat(1'b0);
		for (i = 0; i < 8; i++) begin
			{rtt_nom_en, tdqs_en, odt_pin} = i[2:0];
			repeat (4) tick();
			check(44'({term_dq_en, term_tdqs_en}),
				44'({i[2] & i[0], &i[2:0]}));
		end
		for (i = 0; i < 3; i++) begin
			any_row_open = i == 0;
			sref_req = i == 1;
			u_host_ctrl.set_cke(1'b0);
			repeat (8) tick();
			check(44'(pwr_state), 44'(pst[i]));
			check(44'({cmd_buf_en, odt_buf_en, out_drv_en}),
				44'(i != 1) << 1);
			send(1'b0);
			send(1'b0);
			u_host_ctrl.idle();
			u_host_ctrl.set_cke(1'b1);
			repeat (8) tick();
			check(44'({pwr_state, cmd_buf_en, odt_buf_en,
				out_drv_en}), 44'({PWR_ACTIVE, 3'h7}));
		end
		repeat (4) tick();
		check(44'(cq.size() + sq.size()), '0);
		print_verdict();
	end

	initial begin
		#24000;
		err_count++;
		print_verdict();
	end
endmodule
